// *** common/pet_defines.svh ***
// Purpose: Shared constants of the trigger and event timestamp unit.
// Assumes: Included by the package only; the design file uses its figures without an include of its own.
// Notes: Register offsets are byte addresses on the plain register port.
`ifndef PET_DEFINES_SVH
`define PET_DEFINES_SVH

`define PET_NUM_TRIG 8
`define PET_NUM_EVT 8
`define PET_NUM_GPIO 12
`define PET_QUEUE_DEPTH 8

`define PET_CORE_CLK_MHZ 100
`define PET_NS_PER_TICK (1000 / `PET_CORE_CLK_MHZ)
`define PET_NS_PER_SEC 30'h3b9aca00

`define PET_ADDR_CTL 8'h00
`define PET_ADDR_TDATA_NS 8'h04
`define PET_ADDR_TDATA_SEC 8'h08
`define PET_ADDR_STATUS 8'h0c
`define PET_ADDR_EVT_STATUS 8'h10
`define PET_ADDR_EVT_NS 8'h14
`define PET_ADDR_EVT_SEC 8'h18
`define PET_ADDR_CLK_NS 8'h60
`define PET_ADDR_CLK_SEC 8'h64
`define PET_PAGE_TRIG_CFG 3'h1
`define PET_PAGE_EVT_CFG 3'h2

`define PET_CTL_CLK_EN 0
`define PET_CTL_LOAD_CLK 1
`define PET_CTL_LOAD_TIME 2
`define PET_CTL_LOAD_WIDTH 3
`define PET_CTL_LOAD_PERIOD 4
`define PET_CTL_TSEL_LO 5
`define PET_CTL_TSEL_HI 7
`define PET_CTL_IRQ_TO_GPIO 8
`define PET_CTL_IRQ_PIN_LO 9
`define PET_CTL_IRQ_PIN_HI 12
`define PET_CTL_IRQ_EN 13

`define PET_TCFG_MODE_LO 0
`define PET_TCFG_MODE_HI 1
`define PET_TCFG_PIN_LO 2
`define PET_TCFG_PIN_HI 5
`define PET_TCFG_EN 6

`define PET_ECFG_PIN_LO 0
`define PET_ECFG_PIN_HI 3
`define PET_ECFG_RISE 4
`define PET_ECFG_FALL 5

`define PET_MISSED_MAX 3'h7

`endif

// *** common/pet_pkg.sv ***
// Purpose: Types of the trigger and event timestamp unit.
// Assumes: pet_defines.svh supplies the counts.
// Notes: The main state record lives here so both files agree on the entry layout.
`include "pet_defines.svh"
package pet_pkg;

  typedef enum logic [1:0] {
    TRIG_RISE = 2'b00,
    TRIG_FALL = 2'b01,
    TRIG_PULSE = 2'b10,
    TRIG_PERIODIC = 2'b11
  } pet_trig_mode_t;

  typedef struct packed {
    logic [2:0] chan;
    logic rise;
    logic [2:0] missed;
    logic [31:0] sec;
    logic [29:0] ns;
  } pet_evt_entry_t;

  typedef struct packed {
    logic clkEn;
    logic irqToGpio;
    logic [3:0] irqPin;
    logic irqEn;
    logic [29:0] tdataNs;
    logic [31:0] tdataSec;
    logic [31:0] nowSec;
    logic [29:0] nowNs;
    logic [`PET_NUM_TRIG-1:0][1:0] trigMode;
    logic [`PET_NUM_TRIG-1:0][3:0] trigPin;
    logic [`PET_NUM_TRIG-1:0] trigEn;
    logic [`PET_NUM_TRIG-1:0] trigArmed;
    logic [`PET_NUM_TRIG-1:0] trigPhase;
    logic [`PET_NUM_TRIG-1:0] trigOut;
    logic [`PET_NUM_TRIG-1:0][31:0] actSec;
    logic [`PET_NUM_TRIG-1:0][29:0] actNs;
    logic [`PET_NUM_TRIG-1:0][31:0] endSec;
    logic [`PET_NUM_TRIG-1:0][29:0] endNs;
    logic [`PET_NUM_TRIG-1:0][29:0] width;
    logic [`PET_NUM_TRIG-1:0][29:0] period;
    logic [`PET_NUM_EVT-1:0][3:0] evtPin;
    logic [`PET_NUM_EVT-1:0] evtRise;
    logic [`PET_NUM_EVT-1:0] evtFall;
    logic [`PET_NUM_GPIO-1:0] sync1;
    logic [`PET_NUM_GPIO-1:0] sync2;
    logic [`PET_NUM_GPIO-1:0] sync3;
    logic [`PET_NUM_GPIO-1:0] level;
    logic [2:0] missed;
    logic [31:0] rdData;
    logic [`PET_NUM_GPIO-1:0] gpioOut;
    logic [`PET_NUM_GPIO-1:0] gpioOe;
    logic irqPinN;
  } pet_state_t;

endpackage

// *** hw/pet_event_queue.sv ***
// Purpose: First-in first-out store of captured event timestamps.
// Assumes: Push is refused while full unless a pop happens in the same cycle.
// Notes: The head entry is presented combinationally to the register mux.
`timescale 1ns/1ps
module pet_event_queue #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 69
) (
  input wire logic core_clk, // Core clock.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic push, // Store pushData this cycle.
  input wire logic [WIDTH-1:0] pushData, // Entry to store.
  input wire logic pop, // Drop the head entry this cycle.
  output logic [WIDTH-1:0] headData, // Oldest entry.
  output logic empty, // No entry held.
  output logic full // All entries held.
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] rdPtr;
    logic [AW-1:0] wrPtr;
    logic [AW:0] count;
  } pet_q_state_t;

  pet_q_state_t st_reg;
  pet_q_state_t st_next;
  logic doPop;
  logic doPush;

  assign empty = (st_reg.count == '0);
  assign full = (st_reg.count == (AW + 1)'(DEPTH));
  assign headData = st_reg.mem[st_reg.rdPtr];

  always_comb begin
    st_next = st_reg;
    doPop = pop && !empty;
    doPush = push && (!full || doPop);
    if (doPop) begin
      st_next.rdPtr = (st_reg.rdPtr == AW'(DEPTH - 1)) ? '0 : st_reg.rdPtr + AW'(1);
    end
    if (doPush) begin
      st_next.mem[st_reg.wrPtr] = pushData;
      st_next.wrPtr = (st_reg.wrPtr == AW'(DEPTH - 1)) ? '0 : st_reg.wrPtr + AW'(1);
    end
    if (doPush && !doPop) begin
      st_next.count = st_reg.count + (AW + 1)'(1);
    end else if (doPop && !doPush) begin
      st_next.count = st_reg.count - (AW + 1)'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// *** hw/pet_trigger_timestamp.sv ***
// Purpose: Time-based triggers onto general-purpose pins and timestamping of pin events.
// Assumes: Host uses the plain register port; pins are split into in, out and enable.
// Notes: Times are 32-bit seconds and 30-bit nanoseconds of the internal running clock.
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module pet_trigger_timestamp
  import pet_pkg::*;
(
  input wire logic core_clk, // Core clock, also the time reference.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic [7:0] regAddr, // Register byte address.
  input wire logic [31:0] regWrData, // Register write data.
  input wire logic regWr, // Write strobe.
  input wire logic regRd, // Read strobe.
  output logic [31:0] regRdData, // Read data, valid the cycle after regRd.
  input wire logic [`PET_NUM_GPIO-1:0] gpioIn, // Pin levels from the pads.
  output logic [`PET_NUM_GPIO-1:0] gpioOut, // Pin drive values.
  output logic [`PET_NUM_GPIO-1:0] gpioOe, // Pin output enables.
  output logic powerdownIrqPinN // Shared interrupt pin, active low.
);
  localparam int NT = `PET_NUM_TRIG;
  localparam int NE = `PET_NUM_EVT;
  localparam int NG = `PET_NUM_GPIO;
  localparam logic [29:0] NS_PER_TICK = 30'(`PET_NS_PER_TICK);
  localparam int ENTRY_W = $bits(pet_evt_entry_t);

  pet_state_t st_reg;
  pet_state_t st_next;
  pet_evt_entry_t pushEntry;
  pet_evt_entry_t headEntry;
  logic [ENTRY_W-1:0] headBits;
  logic qPush;
  logic qPop;
  logic qEmpty;
  logic qFull;

  assign headEntry = pet_evt_entry_t'(headBits);
  assign regRdData = st_reg.rdData;
  assign gpioOut = st_reg.gpioOut;
  assign gpioOe = st_reg.gpioOe;
  assign powerdownIrqPinN = st_reg.irqPinN;

  // Nanosecond addition with carry into seconds; the addend must not exceed one second.
  function automatic logic [61:0] pet_add_ns(input logic [31:0] s, input logic [29:0] n,
                                             input logic [29:0] d);
    logic [30:0] sum;
    sum = {1'b0, n} + {1'b0, d};
    if (sum >= {1'b0, `PET_NS_PER_SEC}) begin
      pet_add_ns = {s + 32'h1, 30'(sum - {1'b0, `PET_NS_PER_SEC})};
    end else begin
      pet_add_ns = {s, sum[29:0]};
    end
  endfunction

  function automatic logic pet_reached(input logic [31:0] nowS, input logic [29:0] nowN,
                                       input logic [31:0] tS, input logic [29:0] tN);
    pet_reached = (nowS > tS) || ((nowS == tS) && (nowN >= tN));
  endfunction

  pet_event_queue #(
    .DEPTH(`PET_QUEUE_DEPTH),
    .WIDTH(ENTRY_W)
  ) u_queue (
    .core_clk(core_clk),
    .rstn(rstn),
    .push(qPush),
    .pushData(pushEntry),
    .pop(qPop),
    .headData(headBits),
    .empty(qEmpty),
    .full(qFull)
  );

  always_comb begin
    logic [61:0] t;
    logic [NG-1:0] riseVec;
    logic [NG-1:0] fallVec;
    logic [NG-1:0] pinOut;
    logic [NG-1:0] pinOe;
    logic hit;
    logic lost;
    logic irq;
    logic [2:0] tsel;
    t = '0;
    riseVec = '0;
    fallVec = '0;
    pinOut = '0;
    pinOe = '0;
    hit = 1'b0;
    lost = 1'b0;
    irq = 1'b0;
    tsel = regWrData[`PET_CTL_TSEL_HI:`PET_CTL_TSEL_LO];
    st_next = st_reg;
    qPush = 1'b0;
    pushEntry = '0;
    qPop = 1'b0;

    // Running time; one reference tick per core cycle.
    if (st_reg.clkEn) begin
      t = pet_add_ns(st_reg.nowSec, st_reg.nowNs, NS_PER_TICK);
      st_next.nowSec = t[61:30];
      st_next.nowNs = t[29:0];
    end

    // Triggers. A >= compare is used because the clock steps by more than 1 ns.
    for (int i = 0; i < NT; i++) begin
      if (st_reg.trigEn[i] && st_reg.trigArmed[i]) begin
        unique case (pet_trig_mode_t'(st_reg.trigMode[i]))
          TRIG_RISE: begin
            if (pet_reached(st_reg.nowSec, st_reg.nowNs, st_reg.actSec[i], st_reg.actNs[i])) begin
              st_next.trigOut[i] = 1'b1;
              st_next.trigArmed[i] = 1'b0;
            end
          end
          TRIG_FALL: begin
            if (pet_reached(st_reg.nowSec, st_reg.nowNs, st_reg.actSec[i], st_reg.actNs[i])) begin
              st_next.trigOut[i] = 1'b0;
              st_next.trigArmed[i] = 1'b0;
            end
          end
          TRIG_PULSE, TRIG_PERIODIC: begin
            if (!st_reg.trigPhase[i] &&
                pet_reached(st_reg.nowSec, st_reg.nowNs, st_reg.actSec[i], st_reg.actNs[i])) begin
              st_next.trigOut[i] = 1'b1;
              st_next.trigPhase[i] = 1'b1;
              t = pet_add_ns(st_reg.actSec[i], st_reg.actNs[i], st_reg.width[i]);
              st_next.endSec[i] = t[61:30];
              st_next.endNs[i] = t[29:0];
              if (st_reg.trigMode[i] == TRIG_PERIODIC) begin
                t = pet_add_ns(st_reg.actSec[i], st_reg.actNs[i], st_reg.period[i]);
                st_next.actSec[i] = t[61:30];
                st_next.actNs[i] = t[29:0];
              end
            end else if (st_reg.trigPhase[i] &&
                         pet_reached(st_reg.nowSec, st_reg.nowNs,
                                     st_reg.endSec[i], st_reg.endNs[i])) begin
              st_next.trigOut[i] = 1'b0;
              st_next.trigPhase[i] = 1'b0;
              // A periodic trigger stays armed, which repeats the pulse every programmed period.
              if (st_reg.trigMode[i] == TRIG_PULSE) begin
                st_next.trigArmed[i] = 1'b0;
              end
            end
          end
        endcase
      end
    end

    // Pin input filter: a change counts once the second and third stages agree.
    st_next.sync1 = gpioIn;
    st_next.sync2 = st_reg.sync1;
    st_next.sync3 = st_reg.sync2;
    for (int p = 0; p < NG; p++) begin
      if (st_reg.sync2[p] == st_reg.sync3[p]) begin
        st_next.level[p] = st_reg.sync3[p];
      end
      riseVec[p] = (st_reg.sync2[p] == st_reg.sync3[p]) && st_reg.sync3[p] && !st_reg.level[p];
      fallVec[p] = (st_reg.sync2[p] == st_reg.sync3[p]) && !st_reg.sync3[p] && st_reg.level[p];
    end

    // Register read; the timestamp seconds read completes one entry.
    if (regRd) begin
      st_next.rdData = '0;
      if (regAddr == `PET_ADDR_CTL) begin
        st_next.rdData[`PET_CTL_CLK_EN] = st_reg.clkEn;
        st_next.rdData[`PET_CTL_IRQ_TO_GPIO] = st_reg.irqToGpio;
        st_next.rdData[`PET_CTL_IRQ_PIN_HI:`PET_CTL_IRQ_PIN_LO] = st_reg.irqPin;
        st_next.rdData[`PET_CTL_IRQ_EN] = st_reg.irqEn;
      end else if (regAddr == `PET_ADDR_TDATA_NS) begin
        st_next.rdData[29:0] = st_reg.tdataNs;
      end else if (regAddr == `PET_ADDR_TDATA_SEC) begin
        st_next.rdData = st_reg.tdataSec;
      end else if (regAddr == `PET_ADDR_STATUS) begin
        st_next.rdData[0] = !qEmpty;
        st_next.rdData[1] = qFull;
      end else if (regAddr == `PET_ADDR_EVT_STATUS) begin
        st_next.rdData[2:0] = headEntry.chan;
        st_next.rdData[3] = headEntry.rise;
        st_next.rdData[6:4] = headEntry.missed;
        st_next.rdData[7] = !qEmpty;
      end else if (regAddr == `PET_ADDR_EVT_NS) begin
        st_next.rdData[29:0] = headEntry.ns;
      end else if (regAddr == `PET_ADDR_EVT_SEC) begin
        st_next.rdData = headEntry.sec;
        qPop = !qEmpty;
      end else if (regAddr == `PET_ADDR_CLK_NS) begin
        st_next.rdData[29:0] = st_reg.nowNs;
      end else if (regAddr == `PET_ADDR_CLK_SEC) begin
        st_next.rdData = st_reg.nowSec;
      end else if (regAddr[7:5] == `PET_PAGE_TRIG_CFG && regAddr[1:0] == 2'h0) begin
        st_next.rdData[`PET_TCFG_MODE_HI:`PET_TCFG_MODE_LO] = st_reg.trigMode[regAddr[4:2]];
        st_next.rdData[`PET_TCFG_PIN_HI:`PET_TCFG_PIN_LO] = st_reg.trigPin[regAddr[4:2]];
        st_next.rdData[`PET_TCFG_EN] = st_reg.trigEn[regAddr[4:2]];
      end else if (regAddr[7:5] == `PET_PAGE_EVT_CFG && regAddr[1:0] == 2'h0) begin
        st_next.rdData[`PET_ECFG_PIN_HI:`PET_ECFG_PIN_LO] = st_reg.evtPin[regAddr[4:2]];
        st_next.rdData[`PET_ECFG_RISE] = st_reg.evtRise[regAddr[4:2]];
        st_next.rdData[`PET_ECFG_FALL] = st_reg.evtFall[regAddr[4:2]];
      end
    end

    // Event capture; while the queue has room the lowest channel wins a cycle, any other hits in that cycle add one to missed in total.
    for (int c = 0; c < NE; c++) begin
      if (st_reg.evtPin[c] < 4'(NG)) begin
        if ((riseVec[st_reg.evtPin[c]] && st_reg.evtRise[c]) ||
            (fallVec[st_reg.evtPin[c]] && st_reg.evtFall[c])) begin
          if (!hit && (!qFull || qPop)) begin
            hit = 1'b1;
            qPush = 1'b1;
            pushEntry.chan = 3'(c);
            pushEntry.rise = riseVec[st_reg.evtPin[c]] && st_reg.evtRise[c];
            pushEntry.missed = st_reg.missed;
            pushEntry.sec = st_reg.nowSec;
            pushEntry.ns = st_reg.nowNs;
          end else begin
            lost = 1'b1;
          end
        end
      end
    end
    if (qPush) begin
      st_next.missed = '0;
    end
    if (lost && st_next.missed != `PET_MISSED_MAX) begin
      st_next.missed = st_next.missed + 3'h1;
    end

    // Register write.
    if (regWr) begin
      if (regAddr == `PET_ADDR_CTL) begin
        st_next.clkEn = regWrData[`PET_CTL_CLK_EN];
        st_next.irqToGpio = regWrData[`PET_CTL_IRQ_TO_GPIO];
        st_next.irqPin = regWrData[`PET_CTL_IRQ_PIN_HI:`PET_CTL_IRQ_PIN_LO];
        st_next.irqEn = regWrData[`PET_CTL_IRQ_EN];
        if (regWrData[`PET_CTL_LOAD_CLK]) begin
          st_next.nowSec = st_reg.tdataSec;
          st_next.nowNs = st_reg.tdataNs;
        end
        if (regWrData[`PET_CTL_LOAD_TIME]) begin
          st_next.actSec[tsel] = st_reg.tdataSec;
          st_next.actNs[tsel] = st_reg.tdataNs;
        end
        if (regWrData[`PET_CTL_LOAD_WIDTH]) begin
          st_next.width[tsel] = st_reg.tdataNs;
        end
        if (regWrData[`PET_CTL_LOAD_PERIOD]) begin
          st_next.period[tsel] = st_reg.tdataNs;
        end
      end else if (regAddr == `PET_ADDR_TDATA_NS) begin
        st_next.tdataNs = regWrData[29:0];
      end else if (regAddr == `PET_ADDR_TDATA_SEC) begin
        st_next.tdataSec = regWrData;
      end else if (regAddr[7:5] == `PET_PAGE_TRIG_CFG && regAddr[1:0] == 2'h0) begin
        st_next.trigMode[regAddr[4:2]] = regWrData[`PET_TCFG_MODE_HI:`PET_TCFG_MODE_LO];
        st_next.trigPin[regAddr[4:2]] = regWrData[`PET_TCFG_PIN_HI:`PET_TCFG_PIN_LO];
        st_next.trigEn[regAddr[4:2]] = regWrData[`PET_TCFG_EN];
        st_next.trigArmed[regAddr[4:2]] = regWrData[`PET_TCFG_EN];
        st_next.trigPhase[regAddr[4:2]] = 1'b0;
        // A falling edge needs a high level first, so arming in that mode drives high.
        st_next.trigOut[regAddr[4:2]] = regWrData[`PET_TCFG_EN] &&
            (regWrData[`PET_TCFG_MODE_HI:`PET_TCFG_MODE_LO] == TRIG_FALL);
      end else if (regAddr[7:5] == `PET_PAGE_EVT_CFG && regAddr[1:0] == 2'h0) begin
        st_next.evtPin[regAddr[4:2]] = regWrData[`PET_ECFG_PIN_HI:`PET_ECFG_PIN_LO];
        st_next.evtRise[regAddr[4:2]] = regWrData[`PET_ECFG_RISE];
        st_next.evtFall[regAddr[4:2]] = regWrData[`PET_ECFG_FALL];
      end
    end

    // Pin drive from the values now being registered.
    irq = st_next.irqEn && (st_next.missed != '0 || !qEmpty || qPush);
    for (int p = 0; p < NG; p++) begin
      for (int i = 0; i < NT; i++) begin
        if (st_next.trigEn[i] && st_next.trigPin[i] == 4'(p)) begin
          pinOe[p] = 1'b1;
          pinOut[p] = pinOut[p] | st_next.trigOut[i];
        end
      end
      if (st_next.irqToGpio && st_next.irqPin == 4'(p)) begin
        pinOe[p] = 1'b1;
        pinOut[p] = pinOut[p] | irq;
      end
    end
    st_next.gpioOut = pinOut;
    st_next.gpioOe = pinOe;
    st_next.irqPinN = !(irq && !st_next.irqToGpio);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
      st_reg.irqPinN <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// *** verification/pet_pad_model.sv ***
// Purpose: Pads and the outside devices wired to the general-purpose pins.
// Assumes: The bench sets which pins an outside device drives and to what level.
// Notes: A pin nobody drives wanders every cycle, since it has no pull resistor.
`timescale 1ns/1ps
module pet_pad_model (
  input wire logic core_clk, // Core clock.
  input wire logic [11:0] gpioOut, // Block drive values.
  input wire logic [11:0] gpioOe, // Block drive enables.
  input wire logic [11:0] extVal, // Outside device levels.
  input wire logic [11:0] extEn, // Outside device drive enables.
  output logic [11:0] gpioIn // Resolved pad levels.
);
  logic [11:0] floatVal = 12'h000;
  always @(posedge core_clk) begin
    floatVal <= ~floatVal;
  end
  // A pin serves as input or output; the block's drive enable wins over an outside device.
  assign gpioIn = (gpioOe & gpioOut) | (~gpioOe & extEn & extVal)
    | (~gpioOe & ~extEn & floatVal);
endmodule

// *** verification/pet_trigger_timestamp_assertions.sv ***
// Purpose: Port-level checks of the trigger and event timestamp unit.
// Assumes: Sees only the top ports; control fields are shadowed from writes.
// Notes: Shadows lag nothing, both update at the write edge.
`timescale 1ns/1ps
module pet_trigger_timestamp_checker (
  input wire logic core_clk, // Core clock.
  input wire logic rstn, // Reset, active low.
  input wire logic [7:0] regAddr, // Register address.
  input wire logic [31:0] regWrData, // Write data.
  input wire logic regWr, // Write strobe.
  input wire logic regRd, // Read strobe.
  input wire logic [31:0] regRdData, // Read data.
  input wire logic [11:0] gpioIn, // Pad levels.
  input wire logic [11:0] gpioOut, // Drive values.
  input wire logic [11:0] gpioOe, // Drive enables.
  input wire logic powerdownIrqPinN // Shared interrupt pin.
);
  logic clkOn, irqOn, irqGpio;
  logic [3:0] irqSel;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      clkOn <= 1'b0;
      irqOn <= 1'b0;
      irqGpio <= 1'b0;
      irqSel <= 4'h0;
    end else if (regWr && regAddr == 8'h00) begin
      clkOn <= regWrData[0];
      irqGpio <= regWrData[8];
      irqSel <= regWrData[12:9];
      irqOn <= regWrData[13];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  rst_idle_a: assert property ($rose(rstn) |-> gpioOe == 12'h000 && powerdownIrqPinN)
    else $error("outputs not idle after reset");
  unmapped_rd_a: assert property (regRd && regAddr >= 8'h68 |=> regRdData == 32'h0)
    else $error("unmapped read not zero");
  ctl_bits_a: assert property (regRd && regAddr == 8'h00 |=> regRdData[4:1] == 4'h0)
    else $error("control action bits read back");
  rd_hold_a: assert property (!regRd |=> $stable(regRdData))
    else $error("read data moved without a read");
  status_pair_a: assert property (regRd && regAddr == 8'h0c |=> regRdData[0] || !regRdData[1])
    else $error("queue full but not ready");
  evt_word_a: assert property (regRd && regAddr == 8'h10 |=> regRdData[31:8] == 24'h0)
    else $error("event status upper bits set");
  drive_oe_a: assert property ((gpioOut & ~gpioOe) == 12'h000)
    else $error("pin driven high without enable");
  clk_range_a: assert property (regRd && regAddr == 8'h60 |=> regRdData < 32'h3b9aca00)
    else $error("nanoseconds out of range");
  clk_step_a: assert property (regRd && regAddr == 8'h60 && clkOn ##1 regRd && regAddr == 8'h60
    |=> regRdData == $past(regRdData) + 32'd10 || regRdData < 32'd10)
    else $error("time did not step by one tick");
  irq_quiet_a: assert property ((!irqOn || irqGpio)[*2] |-> powerdownIrqPinN)
    else $error("shared interrupt low while masked or routed");
  irq_route_a: assert property ((irqOn && irqGpio)[*2] |-> gpioOe[irqSel])
    else $error("routed interrupt pin not enabled");
  cover property (regRd && regAddr == 8'h18);
  cover property (irqOn && !powerdownIrqPinN);
  cover property ($rose(gpioOut[4]));
endmodule
bind pet_trigger_timestamp pet_trigger_timestamp_checker chk_i (.core_clk(core_clk),
  .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe),
  .powerdownIrqPinN(powerdownIrqPinN));

// *** verification/tb.sv ***
// Purpose: Self-checking bench of the trigger and event timestamp unit.
// Assumes: Time is loaded to zero nanoseconds, so cycles since load give the time.
// Notes: Time estimates are loose by a few ticks; checks keep a margin of six.
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0, rstn = 1'b0, regWr = 1'b0, regRd = 1'b0, powerdownIrqPinN, last8 = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0, regRdData, rd, r2, ctl = 32'h1;
  logic [11:0] gpioIn, gpioOut, gpioOe, extVal = 12'h000, extEn = 12'h204;
  int n_fail = 0, n_tests = 0, cyc = 0, c0 = 0, rises = 0;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    last8 <= gpioOut[8];
    if (gpioOut[8] && !last8) rises <= rises + 1;
  end
  pet_trigger_timestamp dut (.core_clk(core_clk), .rstn(rstn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe), .powerdownIrqPinN(powerdownIrqPinN));
  pet_pad_model pads (.core_clk(core_clk), .gpioOut(gpioOut), .gpioOe(gpioOe),
    .extVal(extVal), .extEn(extEn), .gpioIn(gpioIn));
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    @(posedge core_clk);
  endtask
  // Read data is valid from the cycle after the strobe and holds until the next read; it is taken at that cycle's falling edge.
  task automatic rdreg(input logic [7:0] a);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(negedge core_clk);
    rd = regRdData;
    @(posedge core_clk);
  endtask
  task automatic upto(input int t);
    while (10 * (cyc - c0) < t) @(posedge core_clk);
  endtask
  task automatic tog(input int p);
    extVal[p] <= ~extVal[p];
    repeat (10) @(posedge core_clk);
  endtask
  task automatic pop(input logic [7:0] st);
    rdreg(8'h10);
    chk("evt_status", {24'h0, st}, rd);
    rdreg(8'h14);
    r2 = rd;
    rdreg(8'h18);
    chk("evt_sec", 32'd5, rd);
  endtask
  task automatic arm(input int i, input logic [1:0] md, input int pin, input int act,
    input int w, input int per);
    wr(8'h04, 32'(act));
    wr(8'h08, 32'd5);
    wr(8'h00, ctl | 32'(i << 5) | 32'h4);
    wr(8'h04, 32'(w));
    wr(8'h00, ctl | 32'(i << 5) | 32'h8);
    wr(8'h04, 32'(per));
    wr(8'h00, ctl | 32'(i << 5) | 32'h10);
    wr(8'h20 + 8'(4 * i), {25'h0, 1'b1, 4'(pin), md});
  endtask
  task automatic s_basic;
    chk("oe_idle", 32'h0, {20'h0, gpioOe});
    chk("irq_idle", 32'h1, {31'h0, powerdownIrqPinN});
    rdreg(8'h0c);
    chk("status_idle", 32'h0, rd);
    wr(8'h70, 32'hffffffff);
    rdreg(8'h70);
    chk("unmapped", 32'h0, rd);
    wr(8'h04, 32'h3fffffff);
    rdreg(8'h04);
    chk("tdata_ns", 32'h3fffffff, rd);
    wr(8'h04, 32'h0);
    wr(8'h08, 32'd5);
    wr(8'h00, 32'h3);
    c0 = cyc;
    rdreg(8'h00);
    chk("ctl", 32'h1, rd);
    regAddr <= 8'h60;
    regRd <= 1'b1;
    @(posedge core_clk);
    @(negedge core_clk);
    r2 = regRdData;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(negedge core_clk);
    chk("clk_step", r2 + 32'd10, regRdData);
    rdreg(8'h64);
    chk("clk_sec", 32'd5, rd);
  endtask
  task automatic s_trig;
    int t;
    t = 10 * (cyc - c0) + 1500;
    arm(0, 2'b10, 4, t, 200, 0);
    arm(1, 2'b10, 4, t + 500, 200, 0);
    arm(2, 2'b01, 6, t, 0, 0);
    arm(3, 2'b11, 8, t + 100, 200, 400);
    arm(4, 2'b00, 10, t + 200, 0, 0);
    chk("fall_armed", 32'h1, {31'h0, gpioOut[6]});
    upto(t + 60);
    chk("pulse_on", 32'h1, {31'h0, gpioOut[4]});
    chk("fall_fired", 32'h0, {31'h0, gpioOut[6]});
    chk("rise_wait", 32'h0, {31'h0, gpioOut[10]});
    upto(t + 300);
    chk("pulse_off", 32'h0, {31'h0, gpioOut[4]});
    chk("rise_fired", 32'h1, {31'h0, gpioOut[10]});
    upto(t + 560);
    chk("or_second", 32'h1, {31'h0, gpioOut[4]});
    upto(t + 800);
    chk("or_low", 32'h0, {31'h0, gpioOut[4]});
    upto(t + 1900);
    chk("period_rises", 32'd5, 32'(rises));
    wr(8'h2c, 32'h0);
    chk("off_oe", 32'h0, {31'h0, gpioOe[8]});
  endtask
  task automatic s_evt;
    int te;
    wr(8'h44, 32'h12);
    wr(8'h58, 32'h22);
    wr(8'h4c, 32'h39);
    te = 10 * (cyc - c0);
    tog(2);
    tog(2);
    tog(9);
    tog(9);
    chk("irq_masked", 32'h1, {31'h0, powerdownIrqPinN});
    rdreg(8'h0c);
    chk("ready", 32'h1, rd);
    wr(8'h00, 32'h2001);
    @(posedge core_clk);
    chk("irq_low", 32'h0, {31'h0, powerdownIrqPinN});
    pop(8'h89);
    // The host would take 35 ns off; here only the raw stamp is bounded.
    chk("ts_window", 32'h1, {31'h0, r2 >= te && r2 <= te + 80});
    pop(8'h86);
    pop(8'h8b);
    pop(8'h83);
    rdreg(8'h0c);
    chk("drained", 32'h0, rd);
    @(posedge core_clk);
    chk("irq_clear", 32'h1, {31'h0, powerdownIrqPinN});
  endtask
  task automatic s_ovf;
    repeat (10) tog(9);
    rdreg(8'h0c);
    chk("full", 32'h3, rd);
    wr(8'h00, 32'h2f01);
    @(posedge core_clk);
    chk("irq_gpio", 32'h1, {31'h0, gpioOut[7] & gpioOe[7]});
    chk("irq_shared_off", 32'h1, {31'h0, powerdownIrqPinN});
    for (int k = 0; k < 8; k++) begin
      pop(k % 2 == 0 ? 8'h8b : 8'h83);
    end
    tog(9);
    pop(8'hab);
    @(posedge core_clk);
    chk("irq_gpio_off", 32'h0, {31'h0, gpioOut[7]});
  endtask
  initial begin
    #300us;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    s_basic();
    s_trig();
    s_evt();
    s_ovf();
    tally_and_finish();
  end
endmodule
